// *** rtl/sdbi_defs.svh ***
// Purpose: Constants for the burst and mode-set logic of the four-bank memory.
// Assumes: One clock at 40 MHz; mode word is {bank select, address}.
// Notes:   Field positions index the 15-bit operating mode word.
`ifndef SDBI_DEFS_SVH
`define SDBI_DEFS_SVH

`define SDBI_MODE_W        15
`define SDBI_MODE_RESET    15'h0000
`define SDBI_BL_LSB        0
`define SDBI_BT_BIT        3
`define SDBI_CL_LSB        4
`define SDBI_TM_LSB        7
`define SDBI_WBL_BIT       9
`define SDBI_AP_BIT        10

`define SDBI_BL_1          3'h0
`define SDBI_BL_2          3'h1
`define SDBI_BL_4          3'h2
`define SDBI_BL_8          3'h3
`define SDBI_BL_FULL       3'h7
`define SDBI_CL_2          3'h2
`define SDBI_CL_3          3'h3

`define SDBI_CLK_PERIOD_NS 25
`define SDBI_T_WR_NS       15
`define SDBI_WR_CYC        ((`SDBI_T_WR_NS + `SDBI_CLK_PERIOD_NS - 1) / `SDBI_CLK_PERIOD_NS)

`endif

// *** rtl/sdbi_pkg.sv ***
// Purpose: Types shared by the burst logic.
// Assumes: Nothing beyond the constants header.
// Notes:   Command codes follow the strobe decode in the top module.
package sdbi_pkg;
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_WRITE, CMD_READ, CMD_MODE
    } sdbi_cmd_t;

    typedef enum logic [1:0] {
        BURST_IDLE, BURST_READ, BURST_WRITE
    } sdbi_burst_t;
endpackage

// *** rtl/sdbi_col_if.sv ***
// Purpose: Carries a burst's start column and word index to the column generator.
// Assumes: Mask is all ones below the burst boundary.
// Notes:   Purely combinational signals.
interface sdbi_col_if #(parameter int COL_W = 9);
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] idx;
    logic [COL_W-1:0] mask;
    logic             interleave;
    logic [COL_W-1:0] col;

    modport gen (input start, input idx, input mask, input interleave, output col);
    modport user (output start, output idx, output mask, output interleave, input col);
endinterface

// *** rtl/sdbi_colgen.sv ***
// Purpose: Column of word idx within a burst, sequential or interleaved.
// Assumes: Mask selects the bits that move inside the burst.
// Notes:   Bits above the mask keep the start column.
module sdbi_colgen (
    sdbi_col_if.gen cif
);
    always_comb begin
        if (cif.interleave) begin
            cif.col = (cif.start & ~cif.mask) | ((cif.start ^ cif.idx) & cif.mask);
        end else begin
            cif.col = (cif.start & ~cif.mask) | ((cif.start + cif.idx) & cif.mask);
        end
    end
endmodule // sdbi_colgen

// *** rtl/sdbi_top.sv ***
// Purpose: Command decode, burst engine, data storage and mode register of a four-bank memory.
// Assumes: All pins are synchronous to CLK_SYS; the controller meets its own timing.
// Notes:   Storage keeps one word per bank and column; the row address is not stored.
`include "sdbi_defs.svh"

module sdbi_top #(
    parameter int COL_W = 9
) (
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST_N,
    input  wire logic                     CS_N,
    input  wire logic                     RAS_N,
    input  wire logic                     CAS_N,
    input  wire logic                     WE_N,
    input  wire logic [1:0]               BANK_SELECT,
    input  wire logic [12:0]              ADDR,
    input  wire logic [3:0]               DQM,
    input  wire logic [31:0]              DQ_IN,
    output logic      [31:0]              DQ_OUT,
    output logic      [3:0]               DQ_OE
);
    import sdbi_pkg::*;

    localparam int DEPTH = 4 << COL_W;
    localparam logic [2:0] WR_CYC = 3'(`SDBI_WR_CYC);

    sdbi_cmd_t              cmd;
    sdbi_burst_t            st_r;
    logic [1:0]             st_bank_r;
    logic [COL_W-1:0]       st_start_r;
    logic [COL_W-1:0]       st_idx_r;
    logic [COL_W-1:0]       st_mask_r;
    logic                   st_full_r;
    logic                   st_ap_r;
    logic [`SDBI_MODE_W-1:0] mode_r;
    logic [3:0]             bank_act_r;
    logic [2:0]             ap_cnt_r;
    logic [1:0]             ap_bank_r;
    logic [31:0]            mem_r [0:DEPTH-1];
    logic [31:0]            pipe0_r;
    logic [31:0]            pipe1_r;
    logic                   pipe0_v_r;
    logic                   pipe1_v_r;
    logic [3:0]             dqm_d1_r;
    logic [31:0]            dq_out_r;
    logic [3:0]             dq_oe_r;

    logic [2:0]             bl_code;
    logic [2:0]             cl_code;
    logic [COL_W-1:0]       bl_mask;
    logic                   bl_full;
    logic [COL_W-1:0]       new_mask;
    logic                   new_full;
    logic                   new_rw;
    logic                   new_wr;
    logic                   new_single;
    logic                   pre_hit;
    logic                   burst_last;
    logic                   burst_go;
    logic                   wr_now;
    logic                   rd_now;
    logic [1:0]             acc_bank;
    logic [COL_W-1:0]       acc_col;
    logic [COL_W+1:0]       acc_idx;
    logic                   ap_end;

    sdbi_col_if #(.COL_W(COL_W)) col_if ();

    sdbi_colgen u_colgen (
        .cif (col_if)
    );

    assign col_if.start      = st_start_r;
    assign col_if.idx        = st_idx_r;
    assign col_if.mask       = st_mask_r;
    assign col_if.interleave = mode_r[`SDBI_BT_BIT];

    // Strobe decode; a deselected cycle is a no-operation.
    always_comb begin
        cmd = CMD_NOP;
        if (!CS_N) begin
            case ({RAS_N, CAS_N, WE_N})
                3'b011:  cmd = CMD_ACT;
                3'b010:  cmd = CMD_PRE;
                3'b100:  cmd = CMD_WRITE;
                3'b101:  cmd = CMD_READ;
                3'b000:  cmd = CMD_MODE;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    assign bl_code = mode_r[`SDBI_BL_LSB +: 3];
    assign cl_code = mode_r[`SDBI_CL_LSB +: 3];

    // Reserved length codes behave as single words; the controller must not use them.
    always_comb begin
        bl_full = 1'b0;
        case (bl_code)
            `SDBI_BL_1:    bl_mask = '0;
            `SDBI_BL_2:    bl_mask = COL_W'(1);
            `SDBI_BL_4:    bl_mask = COL_W'(3);
            `SDBI_BL_8:    bl_mask = COL_W'(7);
            `SDBI_BL_FULL: begin
                bl_mask = '1;
                bl_full = 1'b1;
            end
            default:       bl_mask = '0;
        endcase
    end

    // Read and write commands to a bank that is not open are ignored.
    assign new_wr     = (cmd == CMD_WRITE) && bank_act_r[BANK_SELECT];
    assign new_rw     = new_wr || ((cmd == CMD_READ) && bank_act_r[BANK_SELECT]);
    assign new_mask   = (new_wr && mode_r[`SDBI_WBL_BIT]) ? '0 : bl_mask;
    assign new_full   = bl_full && !(new_wr && mode_r[`SDBI_WBL_BIT]);
    assign new_single = (new_mask == '0) && !new_full;
    assign pre_hit    = (cmd == CMD_PRE) && (ADDR[`SDBI_AP_BIT] || (BANK_SELECT == st_bank_r));
    assign burst_last = (st_idx_r == st_mask_r) && !st_full_r;
    assign burst_go   = (st_r != BURST_IDLE) && !new_rw && !pre_hit;

    // The word moved at this edge: the command's own column, or the running burst's.
    assign wr_now   = new_wr || (burst_go && st_r == BURST_WRITE);
    assign rd_now   = (new_rw && !new_wr) || (burst_go && st_r == BURST_READ);
    assign acc_bank = new_rw ? BANK_SELECT : st_bank_r;
    assign acc_col  = new_rw ? ADDR[COL_W-1:0] : col_if.col;
    assign acc_idx  = {acc_bank, acc_col};

    // Burst engine; a read or write command cuts any running burst.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_r       <= BURST_IDLE;
            st_bank_r  <= 2'h0;
            st_start_r <= '0;
            st_idx_r   <= '0;
            st_mask_r  <= '0;
            st_full_r  <= 1'b0;
            st_ap_r    <= 1'b0;
        end else if (new_rw) begin
            st_r       <= new_single ? BURST_IDLE : (new_wr ? BURST_WRITE : BURST_READ);
            st_bank_r  <= BANK_SELECT;
            st_start_r <= ADDR[COL_W-1:0];
            st_idx_r   <= COL_W'(1);
            st_mask_r  <= new_mask;
            st_full_r  <= new_full;
            st_ap_r    <= ADDR[`SDBI_AP_BIT];
        end else if (pre_hit) begin
            st_r <= BURST_IDLE;
        end else if (st_r != BURST_IDLE) begin
            if (burst_last) begin
                st_r <= BURST_IDLE;
            end else begin
                st_idx_r <= st_idx_r + COL_W'(1);
            end
        end
    end

    // An auto-precharge burst ends at its last word or when another command cuts it.
    assign ap_end = (st_r != BURST_IDLE) && st_ap_r && ((burst_go && burst_last) || new_rw);

    // Open banks and the write recovery timer behind auto precharge.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            bank_act_r <= 4'h0;
            ap_cnt_r   <= 3'h0;
            ap_bank_r  <= 2'h0;
        end else begin
            if (ap_cnt_r != 3'h0) begin
                ap_cnt_r <= ap_cnt_r - 3'h1;
                if (ap_cnt_r == 3'h1) begin
                    bank_act_r[ap_bank_r] <= 1'b0;
                end
            end
            if (ap_end && st_r == BURST_WRITE) begin
                // A timer still running belongs to an earlier write; that bank closes at once.
                if (ap_cnt_r > 3'h1) begin
                    bank_act_r[ap_bank_r] <= 1'b0;
                end
                ap_cnt_r  <= WR_CYC;
                ap_bank_r <= st_bank_r;
            end else if (ap_end) begin
                bank_act_r[st_bank_r] <= 1'b0;
            end
            // A single-word write with auto precharge starts its recovery timer at once.
            if (new_wr && new_single && ADDR[`SDBI_AP_BIT]) begin
                ap_cnt_r  <= WR_CYC;
                ap_bank_r <= BANK_SELECT;
            end else if (new_rw && new_single && ADDR[`SDBI_AP_BIT]) begin
                bank_act_r[BANK_SELECT] <= 1'b0;
            end
            if (cmd == CMD_PRE) begin
                if (ADDR[`SDBI_AP_BIT]) begin
                    bank_act_r <= 4'h0;
                end else begin
                    bank_act_r[BANK_SELECT] <= 1'b0;
                end
            end
            // Activate comes last so that it wins over a close in the same cycle.
            if (cmd == CMD_ACT) begin
                bank_act_r[BANK_SELECT] <= 1'b1;
            end
        end
    end

    // Reset clears the mode word to zero; it holds until the controller programs the mode.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= `SDBI_MODE_RESET;
        end else if (cmd == CMD_MODE) begin
            mode_r <= {BANK_SELECT, ADDR};
        end
    end

    // Storage has no reset; a masked byte lane keeps its old contents.
    always_ff @(posedge CLK_SYS) begin
        if (wr_now) begin
            for (int b = 0; b < 4; b++) begin
                if (!DQM[b]) begin
                    mem_r[acc_idx][b*8 +: 8] <= DQ_IN[b*8 +: 8];
                end
            end
        end
    end

    // Valid bits follow each read word down the pipeline; they and the delayed mask pins gate the output enable.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pipe0_v_r <= 1'b0;
            pipe1_v_r <= 1'b0;
        end else begin
            pipe0_v_r <= rd_now;
            pipe1_v_r <= pipe0_v_r;
        end
    end

    // Read data pipeline; the tap is chosen by the programmed latency.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pipe0_r <= 32'h0000_0000;
            pipe1_r <= 32'h0000_0000;
        end else begin
            pipe1_r <= pipe0_r;
            if (rd_now) begin
                pipe0_r <= mem_r[acc_idx];
            end
        end
    end

    // Mask pins act on the output buffer two clocks later: one stage here, one in the output register.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dqm_d1_r <= 4'h0;
        end else begin
            dqm_d1_r <= DQM;
        end
    end

    // A write that cuts a read relies on the controller masking the words still in flight.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dq_out_r <= 32'h0000_0000;
            dq_oe_r  <= 4'h0;
        end else begin
            if (cl_code == `SDBI_CL_2) begin
                dq_out_r <= pipe0_r;
                dq_oe_r  <= {4{pipe0_v_r}} & ~dqm_d1_r;
            end else begin
                dq_out_r <= pipe1_r;
                dq_oe_r  <= {4{pipe1_v_r}} & ~dqm_d1_r;
            end
        end
    end

    assign DQ_OUT = dq_out_r;
    assign DQ_OE  = dq_oe_r;
endmodule // sdbi_top

// *** verification/sdbi_checker.sv ***
// Purpose: Assertions on the read output enable pins of the burst memory.
// Assumes: The controller lets a burst finish or cuts it before a new read is checked.
// Notes:   Mode word and open banks are shadowed from the command pins.
module sdbi_checker (
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        CS_N,
    input wire logic        RAS_N,
    input wire logic        CAS_N,
    input wire logic        WE_N,
    input wire logic [1:0]  BANK_SELECT,
    input wire logic [12:0] ADDR,
    input wire logic [3:0]  DQM,
    input wire logic [31:0] DQ_OUT,
    input wire logic [3:0]  DQ_OE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [14:0] mode_r;
    logic [3:0]  open_r;
    wire         sel = !CS_N;
    wire         rd  = sel && RAS_N && !CAS_N && WE_N && open_r[BANK_SELECT];
    wire         rdx = sel && RAS_N && !CAS_N && WE_N && !open_r[BANK_SELECT];
    wire         wr  = sel && RAS_N && !CAS_N && !WE_N;
    wire         pre = sel && !RAS_N && CAS_N && !WE_N;
    wire         cl2 = mode_r[6:4] == 3'h2;
    wire [2:0]   bl  = mode_r[2:0];

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            mode_r <= 15'h0000;
        else if (sel && !RAS_N && !CAS_N && !WE_N)
            mode_r <= {BANK_SELECT, ADDR};
    end

    // Auto-precharge commands are taken as closing the bank at once; later reads of it must be ignored.
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N)
            open_r <= 4'h0;
        else if (sel && !RAS_N && CAS_N && WE_N)
            open_r[BANK_SELECT] <= 1'b1;
        else if (pre)
            open_r <= ADDR[10] ? 4'h0 : (open_r & ~(4'h1 << BANK_SELECT));
        else if (sel && RAS_N && !CAS_N && ADDR[10])
            open_r[BANK_SELECT] <= 1'b0;
    end

    property p_oe_cl2; rd && cl2 |-> ##2 DQ_OE == ~$past(DQM, 2); endproperty
    property p_oe_cl3; rd && !cl2 |-> ##2 DQ_OE == 4'h0 ##1 DQ_OE == ~$past(DQM, 2); endproperty
    property p_bl4; rd && bl == 3'h2 && cl2 && DQM == 4'h0 |-> ##2 (DQ_OE == 4'hF) [*4] ##1 DQ_OE == 4'h0; endproperty
    property p_bl8; rd && bl == 3'h3 && cl2 && DQM == 4'h0 |-> ##2 (DQ_OE == 4'hF) [*8] ##1 DQ_OE == 4'h0; endproperty
    property p_full; rd && bl == 3'h7 && cl2 && DQM == 4'h0 |-> ##3 (DQ_OE == 4'hF) [*8]; endproperty
    property p_pre_all; pre && ADDR[10] |-> ##[1:5] DQ_OE == 4'h0; endproperty
    property p_closed; rdx |-> ##1 DQ_OE == 4'h0 ##1 DQ_OE == 4'h0 ##1 DQ_OE == 4'h0; endproperty
    property p_wr_mask; wr && $past(DQM, 2) == 4'hF && $past(DQM) == 4'hF |-> DQ_OE == 4'h0 ##1 DQ_OE == 4'h0; endproperty

    a_oe_cl2: assert property (p_oe_cl2) else $error("Read data late or unmasked at latency two");
    a_oe_cl3: assert property (p_oe_cl3) else $error("Read data late or unmasked at latency three");
    a_bl4: assert property (p_bl4) else $error("Burst of four has wrong length");
    a_bl8: assert property (p_bl8) else $error("Burst of eight has wrong length");
    a_full: assert property (p_full) else $error("Full page burst stopped early");
    a_pre_all: assert property (p_pre_all) else $error("Read burst not ended by closing all banks");
    a_closed: assert property (p_closed) else $error("Read of closed bank produced data");
    a_wr_mask: assert property (p_wr_mask) else $error("Output driven at masked write start");

    c_full: cover property (rd && bl == 3'h7);
    c_cut: cover property (wr && $past(DQM) == 4'hF);
    c_mode: cover property (sel && !RAS_N && !CAS_N && !WE_N);
endmodule // sdbi_checker

bind sdbi_top sdbi_checker i_sdbi_checker (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .BANK_SELECT(BANK_SELECT), .ADDR(ADDR), .DQM(DQM), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE));

// *** verification/sdbi_ctrl_model.sv ***
// Purpose: Memory controller model driving the command, mask and data pins.
// Assumes: Pins change just after a rising edge and hold for one cycle.
// Notes:   Released pins show the inverse of their last value.
module sdbi_ctrl_model #(
    parameter int RCD = 2
) (
    input  wire logic        clk_sys,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       bank_select,
    output logic [12:0]      addr,
    output logic [3:0]       dqm,
    output logic [31:0]      dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {cs_n, ras_n, cas_n, we_n, bank_select, addr, dq_in} = '1;
        dqm = 4'h0;
    end

    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [3:0] m, input logic [31:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= c;
        bank_select <= b;
        addr <= a;
        dqm <= m;
        dq_in <= d;
    endtask

    task automatic nop(input logic [3:0] m);
        cmd(3'h7, ~bank_select, ~addr, m, ~dq_in);
    endtask

    task automatic act(input logic [1:0] b);
        cmd(3'h3, b, 13'h0000, 4'h0, ~dq_in);
        repeat (RCD) nop(4'h0);
    endtask

    task automatic mode(input logic [9:0] w);
        cmd(3'h2, 2'h0, 13'h0400, 4'h0, ~dq_in);
        cmd(3'h0, 2'h0, {3'h0, w[9], 2'h0, w[6:0]}, 4'h0, ~dq_in);
    endtask

    // Deselected cycle carrying write strobes that the memory must ignore.
    task automatic desel(input logic [1:0] b, input logic [12:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= 3'h4;
        bank_select <= b;
        addr <= a;
        dqm <= 4'h0;
        dq_in <= d;
    endtask
endmodule // sdbi_ctrl_model

// *** verification/sdbi_top_tb.sv ***
// Purpose: Self-checking bench for the burst and mode-set logic.
// Assumes: The controller model issues one command per cycle.
// Notes:   A shadow array predicts every stored word from the mode settings, and the masked write's word from its mask.
module sdbi_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] RD = 3'h5;
    localparam logic [2:0] WR = 3'h4;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n, ras_n, cas_n, we_n;
    logic [1:0]  bank_select;
    logic [12:0] addr;
    logic [3:0]  dqm, dq_oe;
    logic [31:0] dq_in, dq_out;
    logic [31:0] shadow [4][512];
    int          err_count = 0;
    int          comparisons = 0;
    int          cl, bl, il, write_burst_length_bit;

    always #12.5 clk_sys = ~clk_sys;

    sdbi_ctrl_model i_sdbi_ctrl_model (.clk_sys(clk_sys), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select(bank_select), .addr(addr), .dqm(dqm), .dq_in(dq_in));
    sdbi_top i_sdbi_top (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .BANK_SELECT(bank_select), .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));

    function automatic logic [8:0] col(input logic [8:0] s, input int i);
        int m;
        m = (bl == 0) ? 511 : bl - 1;
        return 9'(il ? ((s & ~m) | ((s ^ i) & m)) : ((s & ~m) | ((s + i) & m)));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_oe(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] b, input logic [12:0] a, input int n, input logic [31:0] d);
        for (int i = 0; i < n; i++) begin
            if (i == 0)
                i_sdbi_ctrl_model.cmd(WR, b, a, 4'h0, d);
            else
                i_sdbi_ctrl_model.cmd(3'h7, 2'h0, 13'h0000, 4'h0, d + 32'(i));
            if (i == 0 || write_burst_length_bit == 0)
                shadow[b][col(a[8:0], i)] = d + 32'(i);
        end
    endtask

    // Each word is read just after the edge that launches it, so it is settled.
    task automatic rd(input logic [1:0] b, input logic [8:0] c, input int n);
        i_sdbi_ctrl_model.cmd(RD, b, {4'h0, c}, 4'h0, ~dq_in);
        repeat (cl) i_sdbi_ctrl_model.nop(4'h0);
        for (int i = 0; i < n; i++) begin
            #1 chk(dq_out, shadow[b][col(c, i)]);
            chk_oe(dq_oe, 4'hF);
            i_sdbi_ctrl_model.nop(4'h0);
        end
    endtask

    task automatic md(input logic [9:0] w);
        i_sdbi_ctrl_model.mode(w);
        cl = (w[6:4] == 3'h2) ? 2 : 3;
        bl = (w[2:0] == 3'h7) ? 0 : (1 << w[2:0]);
        il = w[3];
        write_burst_length_bit = w[9];
        i_sdbi_ctrl_model.act(2'h0);
        i_sdbi_ctrl_model.act(2'h1);
    endtask

    task automatic test_done;
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100us;
        err_count++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        md(10'h022);
        wr(2'h0, 13'h0004, 4, 32'h0000_0100);
        rd(2'h0, 9'h006, 4);
        wr(2'h0, 13'h0008, 4, 32'h0000_0200);
        md(10'h222);
        wr(2'h0, 13'h0008, 4, 32'h0000_0300);
        md(10'h03A);
        rd(2'h0, 9'h009, 4);
        md(10'h023);
        wr(2'h1, 13'h001E, 8, 32'h0000_0400);
        rd(2'h1, 9'h01A, 8);
        wr(2'h1, 13'h0040, 8, 32'h0000_0700);
        wr(2'h1, 13'h0040, 2, 32'h0000_0500);
        wr(2'h1, 13'h0044, 3, 32'h0000_0800);
        rd(2'h1, 9'h040, 8);
        md(10'h027);
        wr(2'h1, 13'h01FE, 4, 32'h0000_0900);
        rd(2'h1, 9'h1FE, 4);
        repeat (8) i_sdbi_ctrl_model.nop(4'h0);
        md(10'h022);
        wr(2'h0, 13'h0410, 2, 32'h0000_0A00);
        wr(2'h1, 13'h0050, 4, 32'h0000_0B00);
        i_sdbi_ctrl_model.cmd(RD, 2'h0, 13'h0010, 4'h0, ~dq_in);
        repeat (3) i_sdbi_ctrl_model.nop(4'h0);
        #1 chk_oe(dq_oe, 4'h0);
        i_sdbi_ctrl_model.nop(4'h0);
        i_sdbi_ctrl_model.act(2'h0);
        rd(2'h0, 9'h010, 2);
        i_sdbi_ctrl_model.cmd(RD, 2'h1, 13'h0050, 4'hF, ~dq_in);
        i_sdbi_ctrl_model.nop(4'hF);
        wr(2'h1, 13'h0054, 4, 32'h0000_0C00);
        rd(2'h1, 9'h054, 4);
        i_sdbi_ctrl_model.desel(2'h1, 13'h0055, 32'h0000_0000);
        i_sdbi_ctrl_model.cmd(WR, 2'h1, 13'h0054, 4'h3, 32'hFFFF_FFFF);
        shadow[1][9'h054] = 32'hFFFF_0C00;
        rd(2'h1, 9'h054, 4);
        test_done();
    end
endmodule // sdbi_top_tb
